/* rtl/bsf_defs.svh */
// register indices, field positions, reset values and limits of the sample buffer
// assumes a wishbone slave with word-aligned registers (byte address = index * 4)
`ifndef BSF_DEFS_SVH
`define BSF_DEFS_SVH

`define BSF_IDX_STATUS 6'h00
`define BSF_IDX_IRQ_EN 6'h02
`define BSF_IDX_WR_PTR 6'h04
`define BSF_IDX_LOST 6'h05
`define BSF_IDX_RD_PTR 6'h06
`define BSF_IDX_DATA 6'h07
`define BSF_IDX_CFG 6'h08
`define BSF_IDX_DCTRL 6'h09
`define BSF_IDX_SYS 6'h0D

`define BSF_ADR_LSB 2
`define BSF_ADR_MSB 7
`define BSF_CFG_THR_MSB 3
`define BSF_CFG_THR_LSB 0
`define BSF_CFG_OVW_BIT 4
`define BSF_DCTRL_MSB 1
`define BSF_DCTRL_LSB 0
`define BSF_ENABLE_BIT 0

`define BSF_DCTRL_RST 2'h1
`define BSF_LOST_MAX 5'h1F
`define BSF_SLOTS 6'h20
`define BSF_BYTE_LAST 2'h2
`define BSF_RAM_WORDS 128
`define BSF_ELEMS 4

`endif

/* rtl/bsf_pkg.sv */
// types shared by the sample buffer and its surroundings
// assumes bsf_defs.svh is available on the include path
package bsf_pkg;

    typedef struct packed
    {
        logic valid;
        logic [3:0][23:0] elem;
    } bsf_sample_t;

    typedef struct packed
    {
        logic [4:0] wr_ptr;
        logic [4:0] rd_ptr;
        logic [5:0] count;
        logic [4:0] lost;
        logic [1:0] elem_idx;
        logic [1:0] byte_idx;
        logic [3:0] thr;
        logic overwrite;
        logic irq_en;
        logic near_full;
        logic afull_prev;
        logic push_en;
        logic proximity_mode_prev;
        logic [1:0] active_m1;
        logic ack;
        logic [7:0] rdata;
        logic irq;
    } bsf_state_t;

endpackage

/* rtl/bsf_top.sv */
// 32-slot sample buffer with wishbone register port, byte-wise drain and flush logic
// assumes samples, config-write strobes and proximity mode come from logic on mclk
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "bsf_defs.svh"

module bsf_top
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire bsf_pkg::bsf_sample_t sample_i,
    input wire logic cfg_write_i,
    input wire logic proximity_mode_i,
    output logic near_full_irq
);

    bsf_pkg::bsf_state_t s_reg;
    bsf_pkg::bsf_state_t s_next;
    logic [23:0] ram [0:`BSF_RAM_WORDS-1];
    logic [5:0] idx;
    logic bus_go;
    logic rd_go;
    logic wr_go;
    logic pop;
    logic flush;
    logic push_wr;
    logic lose;
    logic afull;
    logic [4:0] diff;
    logic [23:0] rd_word;

    assign idx = wb_adr_i[`BSF_ADR_MSB:`BSF_ADR_LSB];
    assign bus_go = wb_cyc_i && wb_stb_i && !s_reg.ack;
    assign rd_go = bus_go && !wb_we_i;
    assign wr_go = bus_go && wb_we_i && wb_sel_i[0];
    // slot times four plus element index
    assign rd_word = ram[{s_reg.rd_ptr, s_reg.elem_idx}];
    assign diff = s_reg.wr_ptr - wb_dat_i[4:0];

    always_comb
    begin
        s_next = s_reg;
        pop = 1'b0;
        flush = 1'b0;
        push_wr = 1'b0;
        lose = 1'b0;
        afull = 1'b0;
        s_next.ack = bus_go;
        if (rd_go)
        begin
            unique case (idx)
                `BSF_IDX_STATUS: s_next.rdata = {7'h00, s_reg.near_full};
                `BSF_IDX_IRQ_EN: s_next.rdata = {7'h00, s_reg.irq_en};
                `BSF_IDX_WR_PTR: s_next.rdata = {3'h0, s_reg.wr_ptr};
                `BSF_IDX_LOST: s_next.rdata = {3'h0, s_reg.lost};
                `BSF_IDX_RD_PTR: s_next.rdata = {3'h0, s_reg.rd_ptr};
                `BSF_IDX_DATA:
                begin
                    unique case (s_reg.byte_idx)
                        2'h0: s_next.rdata = rd_word[23:16];
                        2'h1: s_next.rdata = rd_word[15:8];
                        default: s_next.rdata = rd_word[7:0];
                    endcase
                end
                `BSF_IDX_CFG: s_next.rdata = {3'h0, s_reg.overwrite, s_reg.thr};
                `BSF_IDX_DCTRL: s_next.rdata = {6'h00, s_reg.active_m1};
                `BSF_IDX_SYS: s_next.rdata = {7'h00, s_reg.push_en};
                default: s_next.rdata = 8'h00;
            endcase
        end
        // reading status clears the flag; a new rise below still wins
        if (rd_go && idx == `BSF_IDX_STATUS)
        begin
            s_next.near_full = 1'b0;
        end
        // data port keeps its address; each read steps one byte
        if (rd_go && idx == `BSF_IDX_DATA)
        begin
            if (s_reg.byte_idx == `BSF_BYTE_LAST)
            begin
                s_next.byte_idx = 2'h0;
                if (s_reg.elem_idx == s_reg.active_m1)
                begin
                    pop = 1'b1;
                    s_next.elem_idx = 2'h0;
                    s_next.rd_ptr = s_reg.rd_ptr + 5'h01;
                    s_next.lost = 5'h00;
                    if (s_reg.count != 6'h00)
                    begin
                        s_next.count = s_reg.count - 6'h01;
                    end
                end
                else
                begin
                    s_next.elem_idx = s_reg.elem_idx + 2'h1;
                end
            end
            else
            begin
                s_next.byte_idx = s_reg.byte_idx + 2'h1;
            end
        end
        if (wr_go)
        begin
            unique case (idx)
                `BSF_IDX_IRQ_EN: s_next.irq_en = wb_dat_i[`BSF_ENABLE_BIT];
                `BSF_IDX_RD_PTR:
                begin
                    // rewind or skip; the next read starts at the first byte of that slot
                    s_next.rd_ptr = wb_dat_i[4:0];
                    s_next.elem_idx = 2'h0;
                    s_next.byte_idx = 2'h0;
                    if (diff == 5'h00 && s_reg.lost != 5'h00)
                    begin
                        s_next.count = `BSF_SLOTS;
                    end
                    else
                    begin
                        s_next.count = {1'b0, diff};
                    end
                end
                `BSF_IDX_CFG:
                begin
                    s_next.thr = wb_dat_i[`BSF_CFG_THR_MSB:`BSF_CFG_THR_LSB];
                    s_next.overwrite = wb_dat_i[`BSF_CFG_OVW_BIT];
                end
                `BSF_IDX_DCTRL:
                begin
                    s_next.active_m1 = wb_dat_i[`BSF_DCTRL_MSB:`BSF_DCTRL_LSB];
                    flush = s_reg.push_en;
                end
                `BSF_IDX_SYS:
                begin
                    s_next.push_en = wb_dat_i[`BSF_ENABLE_BIT];
                    if (wb_dat_i[`BSF_ENABLE_BIT] && !s_reg.push_en)
                    begin
                        flush = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end
        s_next.proximity_mode_prev = proximity_mode_i;
        if (s_reg.push_en && (cfg_write_i || proximity_mode_i != s_reg.proximity_mode_prev))
        begin
            flush = 1'b1;
        end
        if (flush)
        begin
            // stored words stay in RAM and the data port still reads them; only pointers, count, element index and byte position are zeroed
            s_next.wr_ptr = 5'h00;
            s_next.rd_ptr = 5'h00;
            s_next.count = 6'h00;
            s_next.elem_idx = 2'h0;
            s_next.byte_idx = 2'h0;
        end
        else if (sample_i.valid && s_reg.push_en)
        begin
            if (s_next.count != `BSF_SLOTS)
            begin
                push_wr = 1'b1;
                s_next.wr_ptr = s_reg.wr_ptr + 5'h01;
                s_next.count = s_next.count + 6'h01;
            end
            else
            begin
                lose = 1'b1;
                if (s_reg.lost != `BSF_LOST_MAX)
                begin
                    s_next.lost = s_reg.lost + 5'h01;
                end
                if (s_reg.overwrite)
                begin
                    // the oldest slot is reused, so a half-read sample is dropped and reading restarts at the next slot
                    push_wr = 1'b1;
                    s_next.wr_ptr = s_reg.wr_ptr + 5'h01;
                    s_next.rd_ptr = s_next.rd_ptr + 5'h01;
                    s_next.elem_idx = 2'h0;
                    s_next.byte_idx = 2'h0;
                end
            end
        end
        afull = (`BSF_SLOTS - s_next.count) <= {2'h0, s_next.thr};
        s_next.afull_prev = afull;
        if (afull && !s_reg.afull_prev)
        begin
            s_next.near_full = 1'b1;
        end
        s_next.irq = s_next.near_full && s_next.irq_en;
        if (srst)
        begin
            s_next = '0;
            s_next.active_m1 = `BSF_DCTRL_RST;
        end
    end

    always_ff @(posedge mclk)
    begin
        s_reg <= s_next;
    end

    // one whole slot is written per push; unused words are don't care
    always_ff @(posedge mclk)
    begin
        if (push_wr)
        begin
            for (int e = 0; e < `BSF_ELEMS; e++)
            begin
                ram[{s_reg.wr_ptr, 2'(e)}] <= sample_i.elem[e];
            end
        end
    end

    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = {24'h000000, s_reg.rdata};
    assign near_full_irq = s_reg.irq;

    logic last_byte;
    assign last_byte = rd_go && idx == `BSF_IDX_DATA && s_reg.byte_idx == `BSF_BYTE_LAST
        && s_reg.elem_idx == s_reg.active_m1;

    property p_pop_adv;
        @(posedge mclk) disable iff (srst)
        last_byte && !flush && !lose |=> s_reg.rd_ptr == $past(s_reg.rd_ptr) + 5'h01;
    endproperty
    a_pop_adv: assert property (p_pop_adv) else $error("read pointer did not advance after sample");

    property p_mid_hold;
        @(posedge mclk) disable iff (srst)
        rd_go && idx == `BSF_IDX_DATA && !last_byte && !flush && !lose
        |=> s_reg.rd_ptr == $past(s_reg.rd_ptr);
    endproperty
    a_mid_hold: assert property (p_mid_hold) else $error("read pointer moved inside a sample");

    property p_lost_sat;
        @(posedge mclk) disable iff (srst)
        s_reg.lost == `BSF_LOST_MAX && lose |=> s_reg.lost == `BSF_LOST_MAX;
    endproperty
    a_lost_sat: assert property (p_lost_sat) else $error("lost counter wrapped");

    property p_lost_clr;
        @(posedge mclk) disable iff (srst)
        pop && !lose |=> s_reg.lost == 5'h00;
    endproperty
    a_lost_clr: assert property (p_lost_clr) else $error("lost counter not cleared on pop");

    property p_drop;
        @(posedge mclk) disable iff (srst)
        lose && !s_reg.overwrite |=> s_reg.wr_ptr == $past(s_reg.wr_ptr);
    endproperty
    a_drop: assert property (p_drop) else $error("sample pushed while full without overwrite");

    property p_flush;
        @(posedge mclk) disable iff (srst)
        flush |=> s_reg.wr_ptr == 5'h00 && s_reg.rd_ptr == 5'h00 && s_reg.count == 6'h00;
    endproperty
    a_flush: assert property (p_flush) else $error("flush left pointers nonzero");

    property p_hold_off;
        @(posedge mclk) disable iff (srst)
        !s_reg.push_en && !flush |=> s_reg.wr_ptr == $past(s_reg.wr_ptr);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("write pointer moved while push disabled");

    property p_irq;
        @(posedge mclk) disable iff (srst)
        near_full_irq == (s_reg.near_full && s_reg.irq_en);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not gated by flag and enable");

    property p_rd_wr;
        @(posedge mclk) disable iff (srst)
        wr_go && idx == `BSF_IDX_RD_PTR && !flush && !lose
        |=> s_reg.rd_ptr == $past(wb_dat_i[4:0]) ##1 !wb_ack_o;
    endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("read pointer write not taken");

    property p_push_adv;
        @(posedge mclk) disable iff (srst)
        sample_i.valid && s_reg.push_en && !flush && !lose |=> s_reg.wr_ptr == $past(s_reg.wr_ptr) + 5'h01;
    endproperty
    a_push_adv: assert property (p_push_adv) else $error("write pointer did not advance on push");

    property p_ovw;
        @(posedge mclk) disable iff (srst)
        lose && s_reg.overwrite && !wr_go
        |=> s_reg.wr_ptr == $past(s_reg.wr_ptr) + 5'h01 && s_reg.rd_ptr == $past(s_reg.rd_ptr) + 5'h01;
    endproperty
    a_ovw: assert property (p_ovw) else $error("overwrite did not move both pointers");

    property p_lost_inc;
        @(posedge mclk) disable iff (srst)
        lose && s_reg.lost != `BSF_LOST_MAX |=> s_reg.lost == $past(s_reg.lost) + 5'h01;
    endproperty
    a_lost_inc: assert property (p_lost_inc) else $error("lost sample not counted");

    property p_cfg_wr;
        @(posedge mclk) disable iff (srst)
        wr_go && idx == `BSF_IDX_CFG |=> s_reg.thr == $past(wb_dat_i[`BSF_CFG_THR_MSB:`BSF_CFG_THR_LSB]);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("threshold write not taken");

    // the flag must only rise once free space has dropped to the threshold
    property p_nf_rise;
        @(posedge mclk) disable iff (srst)
        !s_reg.near_full ##1 s_reg.near_full |-> (`BSF_SLOTS - s_reg.count) <= {2'h0, s_reg.thr};
    endproperty
    a_nf_rise: assert property (p_nf_rise) else $error("near-full flag set with room above threshold");

    property p_status_clr;
        @(posedge mclk) disable iff (srst)
        rd_go && idx == `BSF_IDX_STATUS && !(afull && !s_reg.afull_prev) |=> !s_reg.near_full;
    endproperty
    a_status_clr: assert property (p_status_clr) else $error("status read did not clear near-full flag");

    c_pop: cover property (@(posedge mclk) disable iff (srst) pop);
    c_overwrite: cover property (@(posedge mclk) disable iff (srst) lose && s_reg.overwrite);
    c_flush: cover property (@(posedge mclk) disable iff (srst) flush);
    c_near_full: cover property (@(posedge mclk) disable iff (srst) !s_reg.near_full ##1 s_reg.near_full);
    c_four: cover property (@(posedge mclk) disable iff (srst) pop && s_reg.active_m1 == 2'h3);

endmodule

/* verification/bsf_src_model.sv */
// sample source standing in for the measurement front ends
// assumes push is called from a bench process that runs on mclk
`timescale 1ns/1ps
module bsf_src_model
(
    input wire logic mclk,
    output bsf_pkg::bsf_sample_t sample_o
);
    initial sample_o = '0;
    // element k of sample s is {s, k, 5A}; words are inverted after a burst so stale data never matches
    task automatic push(input logic [7:0] first, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            sample_o.valid <= 1'b1;
            for (int k = 0; k < 4; k++)
                sample_o.elem[k] <= {first + i[7:0], 6'h00, k[1:0], 8'h5A};
        end
        @(posedge mclk);
        sample_o.valid <= 1'b0;
        sample_o.elem <= ~sample_o.elem;
    endtask
endmodule

/* verification/tb_top.sv */
// self-checking bench: wishbone register tasks plus a sample source model
// assumes bsf_top with two active elements after reset
`timescale 1ns/1ps
`include "bsf_defs.svh"
module tb_top;
    logic mclk, srst, cyc, stb, we, cfg_w, proximity_mode, irq, ack;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, v;
    bsf_pkg::bsf_sample_t smp;
    int bad_count = 0;
    int total_checks = 0;
    bsf_top uut (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sample_i(smp),
        .cfg_write_i(cfg_w), .proximity_mode_i(proximity_mode), .near_full_irq(irq));
    bsf_src_model src (.mclk(mclk), .sample_o(smp));
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // latency is not assumed: the wait polls every clock until ack; a missing ack is left to the watchdog
    task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_chk(input string n, input logic [5:0] idx, input logic [31:0] e);
        wb(1'b0, idx, 32'h0);
        chk(n, e, v);
    endtask
    // reads one whole sample; pointer must hold mid-sample and step after the last byte
    task automatic rd_sample(input logic [7:0] s, input logic [4:0] rp, input int ne);
        for (int k = 0; k < ne; k++)
            for (int b = 0; b < 3; b++)
            begin
                if (k == ne - 1 && b == 2)
                    rd_chk("rd_mid", `BSF_IDX_RD_PTR, {27'h0, rp});
                wb(1'b0, `BSF_IDX_DATA, 32'h0);
                chk("byte", {24'h0, b == 0 ? s : (b == 1 ? k[7:0] : 8'h5A)}, v);
            end
        rd_chk("rd_next", `BSF_IDX_RD_PTR, {27'h0, rp + 5'h01});
    endtask
    initial
    begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        stop_test();
    end
    initial
    begin
        srst = 1'b1;
        {cyc, stb, we, cfg_w, proximity_mode} = 5'h00;
        adr = 8'h00;
        wdat = 32'h0;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        rd_chk("dctrl", `BSF_IDX_DCTRL, 32'h1);
        rd_chk("unmapped", 6'h3F, 32'h0);
        wb(1'b1, `BSF_IDX_IRQ_EN, 32'h1);
        wb(1'b1, `BSF_IDX_CFG, 32'h04);
        wb(1'b1, `BSF_IDX_SYS, 32'h1);
        src.push(8'h10, 3);
        rd_chk("wr", `BSF_IDX_WR_PTR, 32'h3);
        rd_chk("lost", `BSF_IDX_LOST, 32'h0);
        rd_sample(8'h10, 5'h00, 2);
        wb(1'b1, `BSF_IDX_RD_PTR, 32'h0);
        rd_sample(8'h10, 5'h00, 2);
        // 30 fill the buffer, the last 3 are dropped
        src.push(8'h13, 33);
        rd_chk("wr_full", `BSF_IDX_WR_PTR, 32'h1);
        rd_chk("lost3", `BSF_IDX_LOST, 32'h3);
        chk("irq_on", 32'h1, {31'h0, irq});
        rd_chk("status", `BSF_IDX_STATUS, 32'h1);
        chk("irq_off", 32'h0, {31'h0, irq});
        rd_chk("status2", `BSF_IDX_STATUS, 32'h0);
        rd_sample(8'h11, 5'h01, 2);
        rd_chk("lost0", `BSF_IDX_LOST, 32'h0);
        src.push(8'h40, 40);
        rd_chk("lost_sat", `BSF_IDX_LOST, 32'h1F);
        wb(1'b1, `BSF_IDX_CFG, 32'h14);
        src.push(8'h80, 1);
        rd_chk("rd_ovw", `BSF_IDX_RD_PTR, 32'h3);
        rd_sample(8'h13, 5'h03, 2);
        for (int t = 0; t < 3; t++)
        begin
            src.push(8'h90, 2);
            @(posedge mclk);
            if (t == 0)
                cfg_w <= 1'b1;
            if (t == 1)
                proximity_mode <= ~proximity_mode;
            @(posedge mclk);
            cfg_w <= 1'b0;
            if (t == 2)
                wb(1'b1, `BSF_IDX_DCTRL, 32'h1);
            rd_chk("wr_flush", `BSF_IDX_WR_PTR, 32'h0);
            rd_chk("rd_flush", `BSF_IDX_RD_PTR, 32'h0);
        end
        src.push(8'hA0, 2);
        wb(1'b1, `BSF_IDX_SYS, 32'h0);
        wb(1'b1, `BSF_IDX_DCTRL, 32'h1);
        src.push(8'hB0, 1);
        rd_chk("wr_hold", `BSF_IDX_WR_PTR, 32'h2);
        rd_sample(8'hA0, 5'h00, 2);
        // push is off, so changing the element count keeps the stored slots
        wb(1'b1, `BSF_IDX_DCTRL, 32'h3);
        rd_sample(8'hA1, 5'h01, 4);
        wb(1'b1, `BSF_IDX_RD_PTR, 32'h0);
        wb(1'b1, `BSF_IDX_DCTRL, 32'h0);
        rd_sample(8'hA0, 5'h00, 1);
        stop_test();
    end
endmodule
